// ---- mcsrb_pkg.sv ----
package mcsrb_pkg;
    // =========================================================================
    // register addresses (12-bit csr space)
    localparam logic [11:0] ADDR_MACHINE_STATUS    = 12'h0300;
    localparam logic [11:0] ADDR_ISA_DESCRIPTION   = 12'h0301;
    localparam logic [11:0] ADDR_TRAP_VECTOR_BASE  = 12'h0305;
    localparam logic [11:0] ADDR_SCRATCH_WORD      = 12'h0340;
    localparam logic [11:0] ADDR_TRAP_RETURN_PC    = 12'h0341;
    localparam logic [11:0] ADDR_TRAP_CAUSE        = 12'h0342;
    localparam logic [11:0] ADDR_TRAP_VALUE        = 12'h0343;
    localparam logic [11:0] ADDR_PERF_EVENT_SELECT = 12'h07E0;
    localparam logic [11:0] ADDR_PERF_COUNTER_MODE = 12'h07E1;
    localparam logic [11:0] ADDR_PERF_COUNTER_VAL  = 12'h07E2;
    localparam logic [11:0] ADDR_FAST_PIN_OE       = 12'h0803;
    localparam logic [11:0] ADDR_FAST_PIN_INPUT    = 12'h0804;
    localparam logic [11:0] ADDR_FAST_PIN_OUTPUT   = 12'h0805;
    localparam logic [11:0] ADDR_VENDOR_IDENT      = 12'h0F11;
    localparam logic [11:0] ADDR_ARCH_IDENT        = 12'h0F12;
    localparam logic [11:0] ADDR_IMPL_IDENT        = 12'h0F13;
    localparam logic [11:0] ADDR_HART_NUMBER       = 12'h0F14;

    // =========================================================================
    // status field positions
    localparam int STATUS_GIE_BIT  = 3;
    localparam int STATUS_PIE_BIT  = 7;
    localparam int STATUS_PP_LO    = 11;
    localparam int STATUS_PP_HI    = 12;
    localparam int STATUS_TW_BIT   = 21;
    localparam logic [1:0] PRIV_USER    = 2'h0;
    localparam logic [1:0] PRIV_MACHINE = 2'h3;

    // =========================================================================
    // isa description: word length 1, extensions i, m, c, u
    localparam logic [31:0] ISA_VALUE = 32'h4010_1104;

    // =========================================================================
    // trap vector
    localparam int TVEC_BASE_LO = 8;
    localparam logic [1:0] TVEC_MODE_VECTORED = 2'h1;

    // =========================================================================
    // trap cause codes
    localparam logic [4:0] CAUSE_FETCH_FAULT  = 5'h01;
    localparam logic [4:0] CAUSE_ILLEGAL      = 5'h02;
    localparam logic [4:0] CAUSE_BREAKPOINT   = 5'h03;
    localparam logic [4:0] CAUSE_LOAD_FAULT   = 5'h05;
    localparam logic [4:0] CAUSE_STORE_FAULT  = 5'h07;
    localparam logic [4:0] CAUSE_ECALL_USER   = 5'h08;
    localparam logic [4:0] CAUSE_ECALL_MACH   = 5'h0B;
    localparam int CAUSE_IRQ_BIT = 31;

    // =========================================================================
    // perf counter
    localparam int PERF_EVENTS     = 11;
    localparam int PERF_CYCLE_BIT  = 10;
    localparam int MODE_EN_BIT     = 0;
    localparam int MODE_SAT_BIT    = 1;

    // =========================================================================
    // csr operations
    typedef enum logic [1:0] {
        MCSRB_OP_WRITE = 2'h1,
        MCSRB_OP_SET   = 2'h2,
        MCSRB_OP_CLEAR = 2'h3
    } mcsrb_op_t;

    localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
endpackage : mcsrb_pkg

// ---- mcsrb_machine_csr_bank.sv ----
`timescale 1ns/10ps
`default_nettype none
// Contract
// - prior privilege: user 0, machine 3; low bit writable, high mirrors low.
// - timeout wait set: user-mode wait-for-interrupt raises illegal instruction.
// - isa register reports word length code 1, read-only.
// - isa extensions i, m, c, u read 1; all others 0; read-only.
// - trap-vector mode read-only, fixed at vectored 1.
// - trap-vector base holds upper 24 bits, 256-byte aligned, writable.
// - trap entry loads trap pc with next instruction address; software read/write.
// - cause codes: fetch fault 1, load fault 5, store fault 7.
// - cause codes: illegal 2, breakpoint 3, user ecall 8, machine ecall distinct.
// - misaligned fetch cause 0 is never produced.
// - cause interrupt flag set for interrupts, clear for exceptions.
// - interrupt cause carries external source number 1 to 31.
// - trap value: fetch address, opcode, or data address per cause.
// - trap value undefined after interrupts and other exceptions.
// - each select bit enables one event; coincident events count once.
// - cycle event does not count during wait-for-interrupt.
// - saturate control 0 wraps, 1 stops at maximum.
// - enable 0 stops, 1 counts; count readable and writable.
// - output-enable bits 7:0 drive the eight gpio enables.
// - output-value bits 7:0 drive gpio outputs, effective when enabled.
// - input register bits 7:0 return the eight gpio inputs.
// - write, set or clear to read-only register raises illegal instruction.
// - isa register writes accepted without effect.
module mcsrb_machine_csr_bank #(
    parameter int          GPIO_W      = 8,
    parameter int          CNT_W       = 32,
    // arbitrary identification values
    parameter logic [31:0] VENDOR_ID   = 32'h0000_0000,
    parameter logic [31:0] ARCH_ID     = 32'h0000_0000,
    parameter logic [31:0] IMPL_ID     = 32'h0000_0000
) (
    input  wire logic                 sys_clk_i,
    input  wire logic                 srst_i,
    input  wire logic                 csr_access_i,
    input  wire logic [1:0]           csr_op_i,
    input  wire logic [11:0]          csr_addr_i,
    input  wire logic [31:0]          csr_wdata_i,
    input  wire logic                 csr_write_i,
    input  wire logic                 wfi_exec_i,
    input  wire logic                 user_mode_i,
    input  wire logic                 trap_i,
    input  wire logic                 trap_is_irq_i,
    input  wire logic [4:0]           trap_code_i,
    input  wire logic [31:0]          trap_pc_i,
    input  wire logic [31:0]          trap_info_i,
    input  wire logic                 mret_i,
    input  wire logic                 in_wfi_i,
    input  wire logic [10:0]          perf_events_i,
    input  wire logic [GPIO_W-1:0]    gpio_in_i,
    output logic [31:0]               csr_rdata_o,
    output logic                      csr_illegal_o,
    output logic                      global_irq_enable_o,
    output logic [31:0]               trap_vector_base_o,
    output logic [31:0]               trap_return_pc_o,
    output logic [CNT_W-1:0]          perf_count_o,
    output logic [GPIO_W-1:0]         gpio_oe_o,
    output logic [GPIO_W-1:0]         gpio_out_o
);
    // =========================================================================
    // state
    logic                 global_irq_enable;
    logic                 prior_irq_enable;
    logic                 prior_priv_lo;
    logic                 timeout_wait;
    logic [23:0]          tvec_base;
    logic [31:0]          scratch_word;
    logic [31:0]          trap_return_pc;
    logic                 cause_irq;
    logic [4:0]           cause_code;
    logic [31:0]          trap_value;
    logic [10:0]          event_select;
    logic                 saturate_control;
    logic                 count_enable;
    logic [CNT_W-1:0]     perf_count;
    logic [GPIO_W-1:0]    gpio_oe;
    logic [GPIO_W-1:0]    gpio_out;
    logic [GPIO_W-1:0]    gpio_s1;
    logic [GPIO_W-1:0]    gpio_s2;
    logic [GPIO_W-1:0]    gpio_s3;
    logic [GPIO_W-1:0]    gpio_in_q;

    // =========================================================================
    // address decode and read mux
    wire sel_status  = csr_addr_i == mcsrb_pkg::ADDR_MACHINE_STATUS;
    wire sel_isa     = csr_addr_i == mcsrb_pkg::ADDR_ISA_DESCRIPTION;
    wire sel_tvec    = csr_addr_i == mcsrb_pkg::ADDR_TRAP_VECTOR_BASE;
    wire sel_scratch = csr_addr_i == mcsrb_pkg::ADDR_SCRATCH_WORD;
    wire sel_epc     = csr_addr_i == mcsrb_pkg::ADDR_TRAP_RETURN_PC;
    wire sel_cause   = csr_addr_i == mcsrb_pkg::ADDR_TRAP_CAUSE;
    wire sel_tval    = csr_addr_i == mcsrb_pkg::ADDR_TRAP_VALUE;
    wire sel_evsel   = csr_addr_i == mcsrb_pkg::ADDR_PERF_EVENT_SELECT;
    wire sel_mode    = csr_addr_i == mcsrb_pkg::ADDR_PERF_COUNTER_MODE;
    wire sel_count   = csr_addr_i == mcsrb_pkg::ADDR_PERF_COUNTER_VAL;
    wire sel_oe      = csr_addr_i == mcsrb_pkg::ADDR_FAST_PIN_OE;
    wire sel_in      = csr_addr_i == mcsrb_pkg::ADDR_FAST_PIN_INPUT;
    wire sel_out     = csr_addr_i == mcsrb_pkg::ADDR_FAST_PIN_OUTPUT;
    wire sel_vend    = csr_addr_i == mcsrb_pkg::ADDR_VENDOR_IDENT;
    wire sel_arch    = csr_addr_i == mcsrb_pkg::ADDR_ARCH_IDENT;
    wire sel_impl    = csr_addr_i == mcsrb_pkg::ADDR_IMPL_IDENT;
    wire sel_hart    = csr_addr_i == mcsrb_pkg::ADDR_HART_NUMBER;
    wire sel_ro      = sel_in | sel_vend | sel_arch | sel_impl | sel_hart;
    wire sel_any     = sel_status | sel_isa | sel_tvec | sel_scratch | sel_epc | sel_cause
                     | sel_tval | sel_evsel | sel_mode | sel_count | sel_oe | sel_out | sel_ro;

    wire [31:0] status_word = {10'h000, timeout_wait, 8'h00,
                               prior_priv_lo, prior_priv_lo, 3'h0,
                               prior_irq_enable, 3'h0, global_irq_enable, 3'h0};
    wire [31:0] tvec_word   = {tvec_base, 6'h00, mcsrb_pkg::TVEC_MODE_VECTORED};
    wire [31:0] cause_word  = {cause_irq, 26'h000_0000, cause_code};
    wire [31:0] mode_word   = {30'h0000_0000, saturate_control, count_enable};

    wire [31:0] isa_word    = mcsrb_pkg::ISA_VALUE;

    wire [31:0] read_word =
          sel_status  ? status_word
        : sel_isa     ? isa_word
        : sel_tvec    ? tvec_word
        : sel_scratch ? scratch_word
        : sel_epc     ? trap_return_pc
        : sel_cause   ? cause_word
        : sel_tval    ? trap_value
        : sel_evsel   ? {21'h00_0000, event_select}
        : sel_mode    ? mode_word
        : sel_count   ? 32'(perf_count)
        : sel_oe      ? 32'(gpio_oe)
        : sel_in      ? 32'(gpio_in_q)
        : sel_out     ? 32'(gpio_out)
        : sel_vend    ? VENDOR_ID
        : sel_arch    ? ARCH_ID
        : sel_impl    ? IMPL_ID
        : mcsrb_pkg::RESET_ZERO;

    // =========================================================================
    // write data per operation
    wire is_set   = csr_op_i == 2'(mcsrb_pkg::MCSRB_OP_SET);
    wire is_clear = csr_op_i == 2'(mcsrb_pkg::MCSRB_OP_CLEAR);
    wire [31:0] new_word = is_set   ? (read_word | csr_wdata_i)
                         : is_clear ? (read_word & ~csr_wdata_i)
                         : csr_wdata_i;

    // user-mode wfi with timeout wait is illegal
    wire ro_fault   = csr_access_i & csr_write_i & sel_ro;
    wire wfi_fault  = wfi_exec_i & user_mode_i & timeout_wait;
    wire next_illegal = ro_fault | wfi_fault | (csr_access_i & ~sel_any);

    // isa write accepted, no state to change
    wire wr_ok = csr_access_i & csr_write_i & ~sel_ro;
    wire wr_status = wr_ok & sel_status;

    // =========================================================================
    // perf counter
    // cycle event masked in wfi
    wire [10:0] events_eff = perf_events_i
                           & ~(11'(in_wfi_i) << mcsrb_pkg::PERF_CYCLE_BIT);
    wire any_event = |(events_eff & event_select);
    wire at_max    = &perf_count;
    wire count_step = count_enable & any_event & ~(saturate_control & at_max);
    wire [CNT_W-1:0] next_count = perf_count + CNT_W'(1);

    // =========================================================================
    // trap value selection
    // capture per cause
    wire tval_capture = trap_i & ~trap_is_irq_i
                      & ((trap_code_i == mcsrb_pkg::CAUSE_FETCH_FAULT)
                       | (trap_code_i == mcsrb_pkg::CAUSE_ILLEGAL)
                       | (trap_code_i == mcsrb_pkg::CAUSE_LOAD_FAULT)
                       | (trap_code_i == mcsrb_pkg::CAUSE_STORE_FAULT));

    // =========================================================================
    // status and trap registers
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            global_irq_enable <= 1'b0;
            prior_irq_enable  <= 1'b0;
            prior_priv_lo     <= 1'b0;
            timeout_wait      <= 1'b0;
        end else if (trap_i) begin
            prior_irq_enable  <= global_irq_enable;
            global_irq_enable <= 1'b0;
            prior_priv_lo     <= ~user_mode_i;
        end else if (mret_i) begin
            global_irq_enable <= prior_irq_enable;
            prior_irq_enable  <= 1'b0;
        end else if (wr_status) begin
            global_irq_enable <= new_word[mcsrb_pkg::STATUS_GIE_BIT];
            prior_irq_enable  <= new_word[mcsrb_pkg::STATUS_PIE_BIT];
            // only the low privilege bit stored
            prior_priv_lo     <= new_word[mcsrb_pkg::STATUS_PP_LO];
            timeout_wait      <= new_word[mcsrb_pkg::STATUS_TW_BIT];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            tvec_base      <= 24'h00_0000;
            scratch_word   <= mcsrb_pkg::RESET_ZERO;
        end else begin
            if (wr_ok & sel_tvec)
                tvec_base <= new_word[31:mcsrb_pkg::TVEC_BASE_LO];
            if (wr_ok & sel_scratch)
                scratch_word <= new_word;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            trap_return_pc <= mcsrb_pkg::RESET_ZERO;
            cause_irq      <= 1'b0;
            cause_code     <= 5'h00;
            trap_value     <= mcsrb_pkg::RESET_ZERO;
        end else if (trap_i) begin
            trap_return_pc <= trap_pc_i;
            cause_irq      <= trap_is_irq_i;
            // code passed as given by pipeline
            cause_code     <= trap_code_i;
            if (tval_capture)
                trap_value <= trap_info_i;
        end else begin
            if (wr_ok & sel_epc)
                trap_return_pc <= new_word;
            if (wr_ok & sel_cause) begin
                cause_irq  <= new_word[mcsrb_pkg::CAUSE_IRQ_BIT];
                cause_code <= new_word[4:0];
            end
            if (wr_ok & sel_tval)
                trap_value <= new_word;
        end
    end

    // =========================================================================
    // perf registers
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            event_select     <= 11'h000;
            saturate_control <= 1'b0;
            count_enable     <= 1'b0;
            perf_count       <= '0;
        end else begin
            if (wr_ok & sel_evsel)
                event_select <= new_word[10:0];
            if (wr_ok & sel_mode) begin
                saturate_control <= new_word[mcsrb_pkg::MODE_SAT_BIT];
                count_enable     <= new_word[mcsrb_pkg::MODE_EN_BIT];
            end
            // software write has priority over counting
            if (wr_ok & sel_count)
                perf_count <= new_word[CNT_W-1:0];
            else if (count_step)
                perf_count <= next_count;
        end
    end

    // =========================================================================
    // gpio registers and input synchroniser
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            gpio_oe   <= '0;
            gpio_out  <= '0;
            gpio_s1   <= '0;
            gpio_s2   <= '0;
            gpio_s3   <= '0;
            gpio_in_q <= '0;
        end else begin
            if (wr_ok & sel_oe)
                gpio_oe <= new_word[GPIO_W-1:0];
            if (wr_ok & sel_out)
                gpio_out <= new_word[GPIO_W-1:0];
            gpio_s1 <= gpio_in_i;
            gpio_s2 <= gpio_s1;
            gpio_s3 <= gpio_s2;
            for (int i = 0; i < GPIO_W; i++) begin
                if (gpio_s2[i] == gpio_s3[i])
                    gpio_in_q[i] <= gpio_s3[i];
            end
        end
    end

    // =========================================================================
    // registered outputs
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            csr_rdata_o         <= mcsrb_pkg::RESET_ZERO;
            csr_illegal_o       <= 1'b0;
            global_irq_enable_o <= 1'b0;
            trap_vector_base_o  <= {30'h0000_0000, mcsrb_pkg::TVEC_MODE_VECTORED};
            trap_return_pc_o    <= mcsrb_pkg::RESET_ZERO;
            perf_count_o        <= '0;
            gpio_oe_o           <= '0;
            gpio_out_o          <= '0;
        end else begin
            csr_rdata_o         <= csr_access_i ? read_word : mcsrb_pkg::RESET_ZERO;
            csr_illegal_o       <= next_illegal;
            global_irq_enable_o <= global_irq_enable;
            trap_vector_base_o  <= tvec_word;
            trap_return_pc_o    <= trap_return_pc;
            perf_count_o        <= perf_count;
            gpio_oe_o           <= gpio_oe;
            gpio_out_o          <= gpio_out & gpio_oe;
        end
    end
endmodule : mcsrb_machine_csr_bank
`default_nettype wire

// ---- mcsrb_machine_csr_bank_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
module mcsrb_machine_csr_bank_asserts #(
    parameter int GPIO_W = 8,
    parameter int CNT_W  = 32
) (
    input wire logic              sys_clk_i,
    input wire logic              srst_i,
    input wire logic              csr_access_i,
    input wire logic [11:0]       csr_addr_i,
    input wire logic              csr_write_i,
    input wire logic              wfi_exec_i,
    input wire logic              trap_i,
    input wire logic [31:0]       trap_pc_i,
    input wire logic [10:0]       perf_events_i,
    input wire logic [31:0]       csr_rdata_o,
    input wire logic              csr_illegal_o,
    input wire logic [31:0]       trap_vector_base_o,
    input wire logic [31:0]       trap_return_pc_o,
    input wire logic [CNT_W-1:0]  perf_count_o,
    input wire logic [GPIO_W-1:0] gpio_oe_o,
    input wire logic [GPIO_W-1:0] gpio_out_o
);
    // =========================================================================
    // decode of modifying accesses to read-only places
    wire logic ro_hit;
    assign ro_hit = csr_access_i && csr_write_i && !wfi_exec_i
                    && (csr_addr_i == 12'h804 || (csr_addr_i >= 12'hF11 && csr_addr_i <= 12'hF14));

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (srst_i);

    // =========================================================================
    // properties
    // read-only flagged
    property p_ro_ill; ro_hit |=> csr_illegal_o; endproperty
    a_ro_ill: assert property (p_ro_ill) else $error("read-only write not flagged");
    property p_isa; csr_access_i && csr_addr_i == 12'h301 |=> csr_rdata_o == 32'h4010_1104 && !csr_illegal_o; endproperty
    a_isa: assert property (p_isa) else $error("isa read wrong");
    property p_tvec_mode; trap_vector_base_o[7:0] == 8'h01; endproperty
    a_tvec_mode: assert property (p_tvec_mode) else $error("vector low byte wrong");
    property p_trap_pc; trap_i |-> ##2 trap_return_pc_o == $past(trap_pc_i, 2); endproperty
    a_trap_pc: assert property (p_trap_pc) else $error("trap pc not captured");
    property p_gpio_mask; (gpio_out_o & ~gpio_oe_o) == '0; endproperty
    a_gpio_mask: assert property (p_gpio_mask) else $error("output without enable");
    property p_cnt_hold; $past(perf_events_i, 2) == 11'h000 && !$past(csr_access_i, 2) |-> $stable(perf_count_o); endproperty
    a_cnt_hold: assert property (p_cnt_hold) else $error("count moved without event");
    property p_cnt_step; !$past(csr_access_i, 2) |-> perf_count_o == $past(perf_count_o) || perf_count_o == $past(perf_count_o) + 1'b1; endproperty
    a_cnt_step: assert property (p_cnt_step) else $error("count stepped by more than one");
    property p_oe_hold; !$past(csr_access_i, 2) |-> $stable(gpio_oe_o); endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("enable changed without access");

    c_trap: cover property (trap_i);
    c_ro: cover property (ro_hit);
    c_cnt: cover property (perf_count_o == '1);
endmodule : mcsrb_machine_csr_bank_asserts
`default_nettype wire

// ---- mcsrb_gpio_matrix_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module mcsrb_gpio_matrix_model #(
    parameter int GPIO_W = 8
) (
    input  wire logic [GPIO_W-1:0] oe_i,
    input  wire logic [GPIO_W-1:0] out_i,
    output logic      [GPIO_W-1:0] pin_o
);
    // =========================================================================
    // pins loop back; undriven pins float high through the pull-ups
    assign pin_o = (out_i & oe_i) | ~oe_i;
endmodule : mcsrb_gpio_matrix_model
`default_nettype wire

// ---- machine_csr_bank_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module machine_csr_bank_tb;
    localparam logic [1:0] WR = 2'h1, ST = 2'h2, CL = 2'h3;
    logic        sys_clk_i, srst_i, csr_access_i, csr_write_i, wfi_exec_i, user_mode_i, ill;
    logic        trap_i, trap_is_irq_i, mret_i, in_wfi_i, csr_illegal_o, global_irq_enable_o;
    logic [1:0]  csr_op_i;
    logic [11:0] csr_addr_i;
    logic [4:0]  trap_code_i;
    logic [10:0] perf_events_i;
    logic [7:0]  gpio_in_i, gpio_oe_o, gpio_out_o;
    logic [31:0] csr_wdata_i, trap_pc_i, trap_info_i, csr_rdata_o, trap_vector_base_o;
    logic [31:0] trap_return_pc_o, perf_count_o, rd;
    int          fails, n_tests;

    mcsrb_machine_csr_bank dut_u (
        .sys_clk_i, .srst_i, .csr_access_i, .csr_op_i, .csr_addr_i, .csr_wdata_i,
        .csr_write_i, .wfi_exec_i, .user_mode_i, .trap_i, .trap_is_irq_i, .trap_code_i,
        .trap_pc_i, .trap_info_i, .mret_i, .in_wfi_i, .perf_events_i, .gpio_in_i,
        .csr_rdata_o, .csr_illegal_o, .global_irq_enable_o, .trap_vector_base_o,
        .trap_return_pc_o, .perf_count_o, .gpio_oe_o, .gpio_out_o
    );
    mcsrb_gpio_matrix_model gpio_u (.oe_i(gpio_oe_o), .out_i(gpio_out_o), .pin_o(gpio_in_i));

    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    // =========================================================================
    // shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_sim();
        if (fails == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    task automatic csr(input logic [1:0] op, input logic [11:0] a, input logic [31:0] d,
                       input logic w);
        @(posedge sys_clk_i);
        #1;
        csr_access_i = 1'b1;
        csr_op_i = op;
        csr_addr_i = a;
        csr_wdata_i = d;
        csr_write_i = w;
        @(posedge sys_clk_i);
        #1;
        rd = csr_rdata_o;
        ill = csr_illegal_o;
        csr_access_i = 1'b0;
        csr_write_i = 1'b0;
    endtask : csr
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        csr(ST, a, 32'h0000_0000, 1'b0);
        chk(rd, exp);
    endtask : rdchk
    task automatic run_ev(input logic [10:0] ev, input logic wfi, input int n);
        @(posedge sys_clk_i);
        #1;
        perf_events_i = ev;
        in_wfi_i = wfi;
        repeat (n) @(posedge sys_clk_i);
        #1;
        perf_events_i = 11'h000;
        in_wfi_i = 1'b0;
    endtask : run_ev
    task automatic wfi_try(input logic u);
        @(posedge sys_clk_i);
        #1;
        wfi_exec_i = 1'b1;
        user_mode_i = u;
        @(posedge sys_clk_i);
        #1;
        ill = csr_illegal_o;
        wfi_exec_i = 1'b0;
        user_mode_i = 1'b0;
    endtask : wfi_try

    // =========================================================================
    // scenarios
    // identification
    task automatic t_ident();
        csr(WR, 12'h301, 32'hFFFF_FFFF, 1'b1);
        chk({31'h0, ill}, 32'h0000_0000);
        rdchk(12'h301, 32'h4010_1104);
        rdchk(12'hF14, 32'h0000_0000);
        rdchk(12'h805, 32'h0000_0000);
        csr(WR, 12'h340, 32'hA5A5_5A5A, 1'b1);
        rdchk(12'h340, 32'hA5A5_5A5A);
    endtask : t_ident
    task automatic t_ro();
        logic [11:0] ro [5] = '{12'h804, 12'hF11, 12'hF12, 12'hF13, 12'hF14};
        for (int i = 0; i < 5; i++) begin
            for (int op = 1; op < 4; op++) begin
                csr(op[1:0], ro[i], 32'h0000_0001, 1'b1);
                chk({31'h0, ill}, 32'h0000_0001);
            end
        end
    endtask : t_ro
    task automatic t_status();
        csr(WR, 12'h300, 32'hFFFF_FFFF, 1'b1);
        rdchk(12'h300, 32'h0020_1888);
        csr(WR, 12'h300, 32'h0000_1080, 1'b1);
        rdchk(12'h300, 32'h0000_0080);
        mret_i = 1'b1;
        @(posedge sys_clk_i);
        #1;
        mret_i = 1'b0;
        csr(WR, 12'h300, 32'h0020_0000, 1'b1);
        chk({31'h0, global_irq_enable_o}, 32'h0000_0001);
        wfi_try(1'b1);
        chk({31'h0, ill}, 32'h0000_0001);
        wfi_try(1'b0);
        chk({31'h0, ill}, 32'h0000_0000);
        csr(CL, 12'h300, 32'h0020_0000, 1'b1);
        wfi_try(1'b1);
        chk({31'h0, ill}, 32'h0000_0000);
        csr(WR, 12'h305, 32'h1234_56FF, 1'b1);
        rdchk(12'h305, 32'h1234_5601);
        chk(trap_vector_base_o, 32'h1234_5601);
    endtask : t_status
    task automatic t_trap();
        logic [4:0] code [8] = '{5'h01, 5'h02, 5'h03, 5'h05, 5'h07, 5'h08, 5'h0B, 5'h1F};
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk_i);
            #1;
            trap_i = 1'b1;
            trap_is_irq_i = (i == 7);
            trap_code_i = code[i];
            trap_pc_i = 32'h4000_0100 + 32'(i * 4);
            trap_info_i = 32'hBEEF_0000 + 32'(i);
            user_mode_i = i[0];
            @(posedge sys_clk_i);
            #1;
            trap_i = 1'b0;
            user_mode_i = 1'b0;
            rdchk(12'h341, 32'h4000_0100 + 32'(i * 4));
            rdchk(12'h342, {(i == 7), 26'h0, code[i]});
            if (i < 2 || i == 3 || i == 4)
                rdchk(12'h343, 32'hBEEF_0000 + 32'(i));
            csr(ST, 12'h300, 32'h0000_0000, 1'b0);
            chk({30'h0, rd[12:11]}, i[0] ? 32'h0000_0000 : 32'h0000_0003);
        end
    endtask : t_trap
    task automatic t_perf();
        csr(WR, 12'h7E0, 32'h0000_0400, 1'b1);
        csr(WR, 12'h7E1, 32'h0000_0001, 1'b1);
        run_ev(11'h400, 1'b0, 5);
        rdchk(12'h7E2, 32'h0000_0005);
        run_ev(11'h400, 1'b1, 5);
        rdchk(12'h7E2, 32'h0000_0005);
        csr(WR, 12'h7E0, 32'h0000_07FF, 1'b1);
        run_ev(11'h7FF, 1'b0, 3);
        rdchk(12'h7E2, 32'h0000_0008);
        csr(WR, 12'h7E0, 32'h0000_0001, 1'b1);
        run_ev(11'h7FE, 1'b0, 3);
        rdchk(12'h7E2, 32'h0000_0008);
        csr(WR, 12'h7E1, 32'h0000_0000, 1'b1);
        run_ev(11'h001, 1'b0, 3);
        rdchk(12'h7E2, 32'h0000_0008);
        csr(WR, 12'h7E2, 32'hFFFF_FFFE, 1'b1);
        csr(WR, 12'h7E1, 32'h0000_0003, 1'b1);
        run_ev(11'h001, 1'b0, 4);
        rdchk(12'h7E2, 32'hFFFF_FFFF);
        csr(WR, 12'h7E2, 32'hFFFF_FFFE, 1'b1);
        csr(WR, 12'h7E1, 32'h0000_0001, 1'b1);
        run_ev(11'h001, 1'b0, 4);
        rdchk(12'h7E2, 32'h0000_0002);
        chk(perf_count_o, 32'h0000_0002);
    endtask : t_perf
    task automatic t_gpio();
        csr(WR, 12'h803, 32'h0000_000F, 1'b1);
        csr(WR, 12'h805, 32'h0000_0005, 1'b1);
        rdchk(12'h805, 32'h0000_0005);
        chk({24'h0, gpio_oe_o}, 32'h0000_000F);
        chk({24'h0, gpio_out_o}, 32'h0000_0005);
        repeat (6) @(posedge sys_clk_i);
        rdchk(12'h804, 32'h0000_00F5);
        csr(CL, 12'h803, 32'h0000_000F, 1'b1);
        rdchk(12'h805, 32'h0000_0005);
        chk({24'h0, gpio_out_o}, 32'h0000_0000);
    endtask : t_gpio

    initial begin
        repeat (20000) @(posedge sys_clk_i);
        fails++;
        end_sim();
    end

    initial begin
        fails = 0;
        n_tests = 0;
        {csr_access_i, csr_write_i, wfi_exec_i, user_mode_i, trap_i, trap_is_irq_i} = 6'h00;
        {mret_i, in_wfi_i, csr_op_i, csr_addr_i, trap_code_i, perf_events_i} = 32'h0000_0000;
        {csr_wdata_i, trap_pc_i, trap_info_i} = 96'h0;
        srst_i = 1'b1;
        repeat (6) @(posedge sys_clk_i);
        #1;
        srst_i = 1'b0;
        t_ident();
        t_ro();
        t_status();
        t_trap();
        t_perf();
        t_gpio();
        srst_i = 1'b1;
        repeat (6) @(posedge sys_clk_i);
        #1;
        srst_i = 1'b0;
        chk(trap_vector_base_o, 32'h0000_0001);
        rdchk(12'h7E2, 32'h0000_0000);
        end_sim();
    end
endmodule : machine_csr_bank_tb

bind mcsrb_machine_csr_bank mcsrb_machine_csr_bank_asserts #(
    .GPIO_W(GPIO_W), .CNT_W(CNT_W)
) chk_u (
    .sys_clk_i, .srst_i, .csr_access_i, .csr_addr_i, .csr_write_i, .wfi_exec_i, .trap_i,
    .trap_pc_i, .perf_events_i, .csr_rdata_o, .csr_illegal_o, .trap_vector_base_o,
    .trap_return_pc_o, .perf_count_o, .gpio_oe_o, .gpio_out_o
);
`default_nettype wire
